//--- stofl_pkg.sv
/*
  Package for the start-up timeout supervisor: command codes, register
  layouts, reset values and timing counts.
  Assumes a 50 MHz system clock and a PMBus front end that decodes
  transactions into command code, data and strobes.
*/
package stofl_pkg;

  // ------------------------------------------------------------------
  // Command codes
  // ------------------------------------------------------------------
  localparam logic [7:0] CMD_LIMIT = 8'h62;
  localparam logic [7:0] CMD_ACTION = 8'h63;

  // ------------------------------------------------------------------
  // Field layout
  // ------------------------------------------------------------------
  localparam int LIM_MANT_W = 7;
  localparam int LIM_ZERO_W = 4;
  localparam int EXP_W = 5;
  localparam logic [4:0] LIM_EXP = 5'h00;
  localparam int ACT_IGN_BIT = 7;
  localparam int RS_HI_BIT = 5;
  localparam int RS_LO_BIT = 3;
  localparam logic [2:0] RS_NONE = 3'h0;
  localparam logic [2:0] RS_ALL = 3'h7;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [15:0] LIMIT_RST = 16'h0000;
  localparam logic [7:0] ACTION_RST = 8'hBF;
  localparam logic ACT_IGN_RST = 1'b1;
  localparam logic RS5_RST = 1'b1;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ = 50000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int LATE_S = 4;
  localparam int LATE_MS = LATE_S * 1000;
  localparam int RETRY_RAMPS = 7;
  localparam int MS_W = 13;

  typedef enum logic [4:0] {
    STOFL_IDLE = 5'h01,
    STOFL_RAMP = 5'h02,
    STOFL_RUN = 5'h04,
    STOFL_WAIT = 5'h08,
    STOFL_LATCH = 5'h10
  } stofl_state_t;

endpackage : stofl_pkg

//--- stofl_bucket.sv
/*
  Maps a 7-bit limit mantissa onto the effective timeout in ms.
  Output is registered; one cycle after the mantissa changes.
*/
`timescale 1ns/1ps
module stofl_bucket (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [6:0] mant,
  output logic [6:0] eff_ms_r
);

  logic [6:0] eff_ms_nxt;

  always_comb begin
    if (mant <= 7'h06) begin
      eff_ms_nxt = mant;
    end else if (mant <= 7'h09) begin
      eff_ms_nxt = 7'h07;
    end else if (mant <= 7'h0C) begin
      eff_ms_nxt = 7'h0A;
    end else if (mant <= 7'h11) begin
      eff_ms_nxt = 7'h0E;
    end else if (mant <= 7'h16) begin
      eff_ms_nxt = 7'h13;
    end else if (mant <= 7'h20) begin
      eff_ms_nxt = 7'h1B;
    end else if (mant <= 7'h2C) begin
      eff_ms_nxt = 7'h25;
    end else if (mant <= 7'h3E) begin
      eff_ms_nxt = 7'h34;
    end else if (mant <= 7'h56) begin
      eff_ms_nxt = 7'h48;
    end else begin
      eff_ms_nxt = 7'h64;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      eff_ms_r <= 7'h00;
    end else begin
      eff_ms_r <= eff_ms_nxt;
    end
  end

endmodule : stofl_bucket

//--- stofl_supervisor.sv
/*
  Start-up timeout supervisor: limit and action registers, 1 ms time
  base, timeout detection, fault flags, alert and retry sequencing.
  Assumes a PMBus front end presenting single-cycle write/read strobes
  with command code and data, and a power stage reporting ramp state.
*/
`timescale 1ns/1ps
module stofl_supervisor #(
  parameter int TICK_CYCLES = stofl_pkg::TICK_CYC,
  parameter int LATE_MS = stofl_pkg::LATE_MS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic loop_slave,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic restore_all,
  input wire logic store_all,
  input wire logic fault_clear,
  input wire logic enable_cmd,
  input wire logic ramp_start,
  input wire logic [6:0] ramp_ms,
  input wire logic vout_above_uv,
  output logic [15:0] cmd_rdata_r,
  output logic cmd_nack,
  output logic nv_wr_en,
  output logic nv_rs5,
  output logic nv_act_ign,
  output logic output_enable_r,
  output logic status_other_r,
  output logic status_cml_r,
  output logic vout_warn_flag_r,
  output logic status_tonmax_r,
  output logic invalid_command_fault_r,
  output logic invalid_data_r,
  output logic smbalert_n
);

  stofl_pkg::stofl_state_t state_r;
  stofl_pkg::stofl_state_t state_nxt;
  logic [6:0] limit_mant_r;
  logic act_ign_r;
  logic rs5_r;
  logic [6:0] eff_ms_r;
  logic [15:0] div_r;
  logic tick;
  logic [12:0] ms_r;
  logic [9:0] wait_ms_r;
  logic is_ours;
  logic bad_acc;
  logic bad_rs;
  logic timeout;
  logic [15:0] lim_word;
  logic [7:0] act_byte;
  logic [12:0] late_lim;
  logic [9:0] wait_lim;

  assign late_lim = 13'(LATE_MS) + 13'(ramp_ms);
  assign wait_lim = 10'(stofl_pkg::RETRY_RAMPS) * 10'(ramp_ms);
  // ------------------------------------------------------------------
  // Register views
  // ------------------------------------------------------------------
  assign lim_word = {stofl_pkg::LIM_EXP, 4'h0, limit_mant_r};
  assign act_byte = {act_ign_r, 1'b0, {3{rs5_r}}, {3{rs5_r}}};

  assign is_ours = (cmd_code == stofl_pkg::CMD_LIMIT) || (cmd_code == stofl_pkg::CMD_ACTION);
  assign bad_acc = (cmd_wr || cmd_rd) && is_ours && loop_slave;
  assign cmd_nack = bad_acc;
  assign bad_rs = cmd_wr && !loop_slave && (cmd_code == stofl_pkg::CMD_ACTION)
                  && (cmd_wdata[5:3] != stofl_pkg::RS_NONE)
                  && (cmd_wdata[5:3] != stofl_pkg::RS_ALL);

  // Only bit five goes to the store; the other two are rebuilt
  assign nv_wr_en = store_all;
  assign nv_rs5 = rs5_r;
  assign nv_act_ign = act_ign_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      limit_mant_r <= stofl_pkg::LIMIT_RST[6:0];
    end else if (restore_all) begin
      limit_mant_r <= 7'h00;
    end else if (cmd_wr && !loop_slave && cmd_code == stofl_pkg::CMD_LIMIT) begin
      limit_mant_r <= cmd_wdata[6:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      act_ign_r <= stofl_pkg::ACT_IGN_RST;
      rs5_r <= stofl_pkg::RS5_RST;
    end else if (cmd_wr && !loop_slave && !bad_rs
                 && cmd_code == stofl_pkg::CMD_ACTION) begin
      act_ign_r <= cmd_wdata[stofl_pkg::ACT_IGN_BIT];
      rs5_r <= cmd_wdata[stofl_pkg::RS_HI_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmd_rdata_r <= 16'h0000;
    end else if (cmd_rd && !loop_slave) begin
      cmd_rdata_r <= (cmd_code == stofl_pkg::CMD_LIMIT) ? lim_word : {8'h00, act_byte};
    end
  end

  stofl_bucket u_bucket (
    .clock(clock),
    .rst_n(rst_n),
    .mant(limit_mant_r),
    .eff_ms_r(eff_ms_r)
  );

  // ------------------------------------------------------------------
  // Millisecond time base
  // ------------------------------------------------------------------
  // Divider restarts with each attempt so the first tick is a full ms
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 16'h0000;
    end else if (ramp_start || tick) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end
  assign tick = (div_r == 16'(TICK_CYCLES - 1));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ms_r <= 13'h0000;
    end else if (ramp_start) begin
      ms_r <= 13'h0000;
    end else if (state_r == stofl_pkg::STOFL_RAMP && tick && ms_r != 13'h1FFF) begin
      ms_r <= ms_r + 13'h0001;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wait_ms_r <= 10'h000;
    end else if (state_r != stofl_pkg::STOFL_WAIT) begin
      wait_ms_r <= 10'h000;
    end else if (tick) begin
      wait_ms_r <= wait_ms_r + 10'h001;
    end
  end

  // Short limit only trips once the ramp plus four seconds has gone by
  assign timeout = (state_r == stofl_pkg::STOFL_RAMP) && !vout_above_uv
                   && (limit_mant_r != 7'h00)
                   && (eff_ms_r < ramp_ms ? ms_r >= late_lim
                                          : ms_r >= 13'(eff_ms_r));

  // ------------------------------------------------------------------
  // Attempt sequencing
  // ------------------------------------------------------------------
  always_comb begin
    case (state_r)
      stofl_pkg::STOFL_IDLE: begin
        state_nxt = ramp_start ? stofl_pkg::STOFL_RAMP : stofl_pkg::STOFL_IDLE;
      end
      stofl_pkg::STOFL_RAMP: begin
        if (!enable_cmd) begin
          state_nxt = stofl_pkg::STOFL_IDLE;
        end else if (vout_above_uv) begin
          state_nxt = stofl_pkg::STOFL_RUN;
        end else if (timeout && !act_ign_r) begin
          state_nxt = stofl_pkg::STOFL_RUN;
        end else if (timeout) begin
          state_nxt = rs5_r ? stofl_pkg::STOFL_WAIT
                            : stofl_pkg::STOFL_LATCH;
        end else begin
          state_nxt = stofl_pkg::STOFL_RAMP;
        end
      end
      stofl_pkg::STOFL_RUN: begin
        state_nxt = enable_cmd ? stofl_pkg::STOFL_RUN : stofl_pkg::STOFL_IDLE;
      end
      stofl_pkg::STOFL_WAIT: begin
        if (!enable_cmd) begin
          state_nxt = stofl_pkg::STOFL_IDLE;
        end else if (wait_ms_r >= wait_lim) begin
          state_nxt = stofl_pkg::STOFL_IDLE;
        end else begin
          state_nxt = stofl_pkg::STOFL_WAIT;
        end
      end
      stofl_pkg::STOFL_LATCH: begin
        state_nxt = fault_clear ? stofl_pkg::STOFL_IDLE : stofl_pkg::STOFL_LATCH;
      end
      default: begin
        state_nxt = stofl_pkg::STOFL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= stofl_pkg::STOFL_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Output drive gate for the power stage; off while waiting or latched
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      output_enable_r <= 1'b0;
    end else begin
      output_enable_r <= enable_cmd && (state_nxt != stofl_pkg::STOFL_WAIT)
                         && (state_nxt != stofl_pkg::STOFL_LATCH);
    end
  end

  // ------------------------------------------------------------------
  // Status flags; a new event wins over a clear in the same cycle
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_other_r <= 1'b0;
      vout_warn_flag_r <= 1'b0;
      status_tonmax_r <= 1'b0;
    end else if (timeout) begin
      status_other_r <= 1'b1;
      vout_warn_flag_r <= 1'b1;
      status_tonmax_r <= 1'b1;
    end else if (fault_clear) begin
      status_other_r <= 1'b0;
      vout_warn_flag_r <= 1'b0;
      status_tonmax_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      invalid_command_fault_r <= 1'b0;
    end else if (bad_acc) begin
      invalid_command_fault_r <= 1'b1;
    end else if (fault_clear) begin
      invalid_command_fault_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_cml_r <= 1'b0;
      invalid_data_r <= 1'b0;
    end else if (bad_rs || bad_acc) begin
      status_cml_r <= 1'b1;
      invalid_data_r <= invalid_data_r | bad_rs;
    end else if (fault_clear) begin
      status_cml_r <= 1'b0;
      invalid_data_r <= 1'b0;
    end
  end

  assign smbalert_n = !(status_tonmax_r || invalid_command_fault_r || invalid_data_r);

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  property p_disabled_no_fault;
    @(posedge clock) disable iff (!rst_n)
    (limit_mant_r == 7'h00 && !status_tonmax_r) |=> !status_tonmax_r;
  endproperty
  a_disabled_no_fault: assert property (p_disabled_no_fault) else $error("timeout while disabled");
  property p_fault_alert;
    @(posedge clock) disable iff (!rst_n)
    timeout |=> (status_tonmax_r && vout_warn_flag_r && status_other_r) ##0 !smbalert_n;
  endproperty
  a_fault_alert: assert property (p_fault_alert) else $error("fault not flagged");
  property p_slave_nack;
    @(posedge clock) disable iff (!rst_n)
    (cmd_wr && loop_slave && cmd_code == stofl_pkg::CMD_LIMIT) |->
      cmd_nack ##1 ($stable(limit_mant_r) && invalid_command_fault_r);
  endproperty
  a_slave_nack: assert property (p_slave_nack) else $error("slave access not refused");
  property p_bad_retry;
    @(posedge clock) disable iff (!rst_n)
    bad_rs |=> $stable(rs5_r) && status_cml_r && invalid_data_r && !smbalert_n;
  endproperty
  a_bad_retry: assert property (p_bad_retry) else $error("bad retry accepted");
  property p_ignore_keeps_on;
    @(posedge clock) disable iff (!rst_n)
    (timeout && !act_ign_r && enable_cmd) |=> output_enable_r;
  endproperty
  a_ignore_keeps_on: assert property (p_ignore_keeps_on) else $error("ignore mode shut down");
  property p_act_shuts;
    @(posedge clock) disable iff (!rst_n)
    (timeout && act_ign_r && !vout_above_uv) |=> !output_enable_r;
  endproperty
  a_act_shuts: assert property (p_act_shuts) else $error("act mode kept running");
  property p_latch_holds;
    @(posedge clock) disable iff (!rst_n)
    (state_r == stofl_pkg::STOFL_LATCH && !fault_clear) |=> state_r == stofl_pkg::STOFL_LATCH;
  endproperty
  a_latch_holds: assert property (p_latch_holds) else $error("latch left uncleared");
  property p_delay_mirror;
    @(posedge clock) disable iff (!rst_n)
    (cmd_rd && !loop_slave && cmd_code == stofl_pkg::CMD_ACTION) |=>
      cmd_rdata_r[2:0] == {3{cmd_rdata_r[5]}} && cmd_rdata_r[4:3] == {2{cmd_rdata_r[5]}};
  endproperty
  a_delay_mirror: assert property (p_delay_mirror) else $error("delay field mismatch");
  property p_restore;
    @(posedge clock) disable iff (!rst_n)
    restore_all |=> limit_mant_r == 7'h00;
  endproperty
  a_restore: assert property (p_restore) else $error("limit not restored");

endmodule : stofl_supervisor

//--- stofl_host.sv
/*
  Host controller model: issues single-cycle register writes and reads
  on the command strobes of the start-up timeout supervisor.
  Assumes the bench calls xfer and owns the clock.
*/
`timescale 1ns/1ps
module stofl_host (
  input wire logic clock,
  input wire logic cmd_nack,
  input wire logic [15:0] cmd_rdata_r,
  output logic cmd_wr,
  output logic cmd_rd,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata
);
  initial begin
    cmd_wr = 1'h0;
    cmd_rd = 1'h0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // ------------------------------------------------------------------
  // One transfer: strobe for one cycle, refusal seen in that cycle
  // ------------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] code,
                      input logic [15:0] data, output logic nack,
                      output logic [15:0] rdata);
    @(posedge clock);
    cmd_wr <= wr;
    cmd_rd <= ~wr;
    cmd_code <= code;
    cmd_wdata <= data;
    #1;
    nack = cmd_nack;
    @(posedge clock);
    cmd_wr <= 1'h0;
    cmd_rd <= 1'h0;
    // Released lines invert, so a stale value is never mistaken for data
    cmd_code <= ~code;
    cmd_wdata <= ~data;
    #1;
    rdata = cmd_rdata_r;
  endtask : xfer
endmodule : stofl_host

//--- stofl_tb.sv
/*
  Self-checking bench for the start-up timeout supervisor.
  Assumes stofl_pkg, stofl_supervisor and stofl_host are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  localparam int TICK = 10;
  localparam int LATE = 5;
  logic clock, rst_n, loop_slave, restore_all, store_all, fault_clear;
  logic enable_cmd, ramp_start, vout_above_uv, cmd_wr, cmd_rd, cmd_nack;
  logic nv_wr_en, nv_rs5, nv_act_ign, output_enable_r, status_other_r;
  logic status_cml_r, vout_warn_flag_r, status_tonmax_r, nk;
  logic invalid_command_fault_r, invalid_data_r, smbalert_n;
  logic [6:0] ramp_ms;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata_r, rd, d;
  int n_errors = 0;
  int num_checks = 0;
  int seed = 97256;
  int lim_m, act_m, rs5_m;
  int bucket_set[6] = '{1, 6, 7, 9, 10, 13};

  stofl_supervisor #(.TICK_CYCLES(TICK), .LATE_MS(LATE)) i_stofl_supervisor (
    .clock, .rst_n, .loop_slave, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata,
    .restore_all, .store_all, .fault_clear, .enable_cmd, .ramp_start, .ramp_ms,
    .vout_above_uv, .cmd_rdata_r, .cmd_nack, .nv_wr_en, .nv_rs5, .nv_act_ign,
    .output_enable_r, .status_other_r, .status_cml_r, .vout_warn_flag_r,
    .status_tonmax_r, .invalid_command_fault_r, .invalid_data_r, .smbalert_n);
  stofl_host i_stofl_host (.clock, .cmd_nack, .cmd_rdata_r, .cmd_wr, .cmd_rd,
    .cmd_code, .cmd_wdata);

  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end

  // ------------------------------------------------------------------
  // Reference model and helpers
  // ------------------------------------------------------------------
  function automatic int bucket(input int v);
    int hi[8] = '{9, 12, 17, 22, 32, 44, 62, 86};
    int ef[8] = '{7, 10, 14, 19, 27, 37, 52, 72};
    if (v <= 6) begin
      return v;
    end
    for (int i = 0; i < 8; i++) begin
      if (v <= hi[i]) begin
        return ef[i];
      end
    end
    return 100;
  endfunction : bucket

  function automatic logic [15:0] act_word();
    return 16'(act_m * 128 + rs5_m * 63);
  endfunction : act_word

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim();
    if (n_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  task automatic wr(input logic [7:0] c, input logic [15:0] v);
    i_stofl_host.xfer(1'h1, c, v, nk, rd);
  endtask : wr

  task automatic rdb(input logic [7:0] c);
    i_stofl_host.xfer(1'h0, c, 16'h0000, nk, rd);
  endtask : rdb

  task automatic clr();
    @(posedge clock);
    fault_clear <= 1'h1;
    @(posedge clock);
    fault_clear <= 1'h0;
  endtask : clr

  task automatic rst_chk();
    rst_n <= 1'h0;
    repeat (12) @(posedge clock);
    rst_n <= 1'h1;
    lim_m = 0;
    act_m = 1;
    rs5_m = 1;
    rdb(stofl_pkg::CMD_LIMIT);
    chk(rd, 16'h0000);
    rdb(stofl_pkg::CMD_ACTION);
    chk(rd, 16'h00BF);
    chk(smbalert_n, 1'h1);
  endtask : rst_chk

  // One start-up attempt; no fault expected for a zero limit or good output
  task automatic run_to(input int mt, input int rmp, input logic v);
    int c;
    int e;
    c = 0;
    e = (mt == 0 || v) ? 0 : bucket(mt);
    if (e != 0 && e < rmp) begin
      e = rmp + LATE;
    end
    wr(stofl_pkg::CMD_LIMIT, 16'(mt));
    lim_m = mt;
    @(posedge clock);
    ramp_ms <= 7'(rmp);
    vout_above_uv <= v;
    ramp_start <= 1'h1;
    @(posedge clock);
    ramp_start <= 1'h0;
    while (status_tonmax_r !== 1'h1 && c < 1500) begin
      @(posedge clock);
      #1;
      c++;
    end
    if (e == 0) begin
      chk(status_tonmax_r, 1'h0);
      return;
    end
    if (c >= 1500) begin
      n_errors++;
      end_sim();
    end
    chk(16'(c / TICK), 16'(e));
    chk({vout_warn_flag_r, status_other_r, smbalert_n}, 3'h6);
    @(posedge clock);
    #1;
    chk(output_enable_r, 1'(act_m == 0));
    repeat (7 * rmp * TICK - 5) @(posedge clock);
    #1;
    chk(output_enable_r, 1'(act_m == 0));
    repeat (15) @(posedge clock);
    #1;
    chk(output_enable_r, 1'(act_m == 0 || rs5_m == 1));
    if (act_m == 1 && rs5_m == 0) begin
      ramp_start <= 1'h1;
      @(posedge clock);
      ramp_start <= 1'h0;
      repeat (3) @(posedge clock);
      #1;
      chk(output_enable_r, 1'h0);
    end
    clr();
  endtask : run_to

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    rst_n = 1'h0;
    loop_slave = 1'h0;
    restore_all = 1'h0;
    store_all = 1'h0;
    fault_clear = 1'h0;
    enable_cmd = 1'h1;
    ramp_start = 1'h0;
    vout_above_uv = 1'h0;
    ramp_ms = 7'h01;
    rst_chk();
    for (int i = 0; i < 6; i++) begin
      d = 16'($random(seed));
      wr(stofl_pkg::CMD_LIMIT, d);
      lim_m = d[6:0];
      rdb(stofl_pkg::CMD_LIMIT);
      chk(rd, 16'(lim_m));
    end
    for (int r = 0; r < 8; r++) begin
      d = 16'($random(seed));
      d[5:3] = 3'(r);
      wr(stofl_pkg::CMD_ACTION, d);
      if (r == 0 || r == 7) begin
        act_m = d[7];
        rs5_m = d[5];
      end
      chk({invalid_data_r, status_cml_r, smbalert_n},
          (r == 0 || r == 7) ? 3'h1 : 3'h6);
      rdb(stofl_pkg::CMD_ACTION);
      chk(rd, act_word());
      clr();
    end
    @(posedge clock);
    store_all <= 1'h1;
    #1;
    chk({nv_wr_en, nv_rs5, nv_act_ign}, {1'h1, 1'(rs5_m), 1'(act_m)});
    @(posedge clock);
    store_all <= 1'h0;
    wr(stofl_pkg::CMD_LIMIT, 16'h0009);
    @(posedge clock);
    restore_all <= 1'h1;
    @(posedge clock);
    restore_all <= 1'h0;
    lim_m = 0;
    rdb(stofl_pkg::CMD_LIMIT);
    chk(rd, 16'h0000);
    @(posedge clock);
    loop_slave <= 1'h1;
    wr(stofl_pkg::CMD_LIMIT, 16'h0005);
    chk({nk, invalid_command_fault_r, smbalert_n}, 3'h6);
    rdb(stofl_pkg::CMD_ACTION);
    chk(nk, 1'h1);
    @(posedge clock);
    loop_slave <= 1'h0;
    rdb(stofl_pkg::CMD_LIMIT);
    chk(rd, 16'(lim_m));
    chk(nk, 1'h0);
    clr();
    // Attempts that never time out leave the sequencer busy: reset after
    rst_chk();
    run_to(0, 1, 1'h0);
    rst_chk();
    run_to(1, 1, 1'h1);
    rst_chk();
    foreach (bucket_set[i]) begin
      run_to(bucket_set[i], 1, 1'h0);
    end
    run_to(1 + ($random(seed) & 32'h0000007E), 1, 1'h0);
    run_to(1, 3, 1'h0);
    run_to(2, 2, 1'h0);
    wr(stofl_pkg::CMD_ACTION, 16'h0080);
    act_m = 1;
    rs5_m = 0;
    run_to(3, 1, 1'h0);
    wr(stofl_pkg::CMD_ACTION, 16'h003F);
    act_m = 0;
    rs5_m = 1;
    run_to(2, 1, 1'h0);
    // Commanded off drops the output drive; back on restores it
    @(posedge clock);
    enable_cmd <= 1'h0;
    @(posedge clock);
    #1;
    chk(output_enable_r, 1'h0);
    @(posedge clock);
    enable_cmd <= 1'h1;
    repeat (2) @(posedge clock);
    #1;
    chk(output_enable_r, 1'h1);
    end_sim();
  end

endmodule : testbench
